// >>> rtl/rx_front_pkg.sv
/*
  Package for the port receive front end: modes, sync period, synchroniser depth.
  Assumes one system clock (clk_sys, 125 MHz) that samples all link clocks.
*/
package rx_front_pkg;
  // ==========================================================================
  // Modes
  typedef enum logic [1:0] {
    MODE_MII = 2'b00,
    MODE_SMII = 2'b01,
    MODE_SRCSYNC = 2'b11
  } port_mode_t;

  // ==========================================================================
  // Framing and timing
  localparam int SEG_BITS = 10;
  localparam logic [3:0] SEG_LAST = 4'h9;
  localparam logic [3:0] SEG_RESET = 4'h0;
  localparam int SYNC_STAGES = 3;
  localparam int NIBBLE_W = 4;
  localparam int SERIAL_PORTS = 4;
endpackage

// >>> rtl/in_sync3.sv
/*
  Three-stage input synchroniser with edge detection for a bus of pins.
  Assumes inputs are asynchronous to clk; stage 1 feeds stage 2 only.
*/
`timescale 1ns/1ns
module in_sync3 #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [W-1:0] pin,
  output logic [W-1:0] level,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;
  logic [W-1:0] held;
  logic [W-1:0] agree;

  // ==========================================================================
  // Sync chain; runs through reset so the accepted level is known at release
  always_ff @(posedge clk) begin
    s1 <= pin;
    s2 <= s1;
    s3 <= s2;
  end

  // Accepted level: a change counts once s2 and s3 agree
  assign agree = ~(s2 ^ s3);
  always_ff @(posedge clk) begin
    if (srst) begin
      held <= s3; // Track the pin in reset, so no false edge follows release
    end else begin
      held <= (agree & s3) | (~agree & held);
    end
  end

  assign level = held;
  assign rise = agree & s3 & ~held;
  assign fall = agree & ~s3 & held;
endmodule // in_sync3

// >>> rtl/rx_front.sv
/*
  Receive and framing-sync front end of one port: MII nibble capture or four
  SMII serial lines, plain or source-synchronous, and the shared sync pin.
  Link clocks are sampled, not used as clocks: every rise is found in clk_sys
  through the three-stage chain, and the data lines pass a chain of the same
  depth, so both stay aligned. A capture pulse follows a pin edge by three
  to four clk_sys periods.
  Assumes link clocks are slow enough for clk_sys to find their edges (each
  level lasting at least two clk_sys periods, so a full-rate serial link needs
  a faster system clock), and mode is static while port_enable is high.
  Mode code 10 captures nothing but still drives the shared pin low.
  The shared pin stays undriven through reset and in MII mode; software must
  pick the mode before it raises port_enable, and framing restarts with every
  enable, so the first sync pulse follows the first link clock rise.
*/
`timescale 1ns/1ns
module rx_front
  import rx_front_pkg::*;
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic port_enable,
  input wire logic [1:0] port_mode,
  input wire logic port_rx_clock,
  input wire logic shared_serial_ref_clock,
  input wire logic srcsync_tx_clock,
  input wire logic [NIBBLE_W-1:0] port_rx_nibble,
  input wire logic port_rx_valid,
  input wire logic port_collision,
  input wire logic sense_sync_in,
  output logic sense_sync_out,
  output logic sense_sync_oe,
  output logic [NIBBLE_W-1:0] mii_nibble,
  output logic mii_nibble_valid,
  output logic carrier_sense,
  output logic collision,
  output logic [SERIAL_PORTS-1:0] serial_bit,
  output logic serial_bit_valid,
  output logic serial_seg_start
);
  logic [NIBBLE_W-1:0] nib_lvl;
  logic rxc_rise;
  logic refc_rise;
  logic txc_rise;
  logic dv_lvl;
  logic col_lvl;
  logic crs_lvl;
  logic [2:0] clk_rise;
  logic [3:0] tx_seg_cnt;
  logic [3:0] next_tx_seg_cnt;
  logic bit_edge;
  logic sync_edge;
  logic enabled;
  port_mode_t mode;

  // ==========================================================================
  // Mode decoding shared by the capture, status, framing and sync paths
  function automatic logic is_mii_on(input logic en, input port_mode_t m);
    return en && m == MODE_MII;
  endfunction

  function automatic logic is_serial_on(input logic en, input port_mode_t m);
    return en && (m == MODE_SMII || m == MODE_SRCSYNC);
  endfunction

  // Static mode; a disabled port ignores every receive input
  assign mode = port_mode_t'(port_mode);
  assign enabled = port_enable;

  // ==========================================================================
  // Synchronisers: link clocks as sampled inputs
  in_sync3 #(.W(3)) u_clk_sync (
    .clk(clk_sys),
    .srst(srst),
    .pin({srcsync_tx_clock, shared_serial_ref_clock, port_rx_clock}),
    .level(),
    .rise(clk_rise),
    .fall()
  );
  assign rxc_rise = clk_rise[0];
  assign refc_rise = clk_rise[1];
  assign txc_rise = clk_rise[2];

  // Data, valid/rx-sync, collision and carrier sense
  in_sync3 #(.W(NIBBLE_W + 3)) u_data_sync (
    .clk(clk_sys),
    .srst(srst),
    .pin({sense_sync_in, port_collision, port_rx_valid, port_rx_nibble}),
    .level({crs_lvl, col_lvl, dv_lvl, nib_lvl}),
    .rise(),
    .fall()
  );

  // Sampling edge per mode
  assign bit_edge = (mode == MODE_SRCSYNC) ? rxc_rise :
                    (mode == MODE_SMII) ? refc_rise : 1'b0;

  // ==========================================================================
  // MII capture: nibble taken on rx clock edge only while valid
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      mii_nibble <= 4'h0;
      mii_nibble_valid <= 1'b0;
    end else begin
      mii_nibble_valid <= 1'b0;
      if (is_mii_on(enabled, mode) && rxc_rise && dv_lvl) begin
        mii_nibble <= nib_lvl;
        mii_nibble_valid <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // MII carrier sense: synchronised pin, forced low outside MII
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      carrier_sense <= 1'b0;
    end else begin
      carrier_sense <= is_mii_on(enabled, mode) && crs_lvl;
    end
  end

  // MII collision: the pin has no effect in either serial mode
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      collision <= 1'b0;
    end else begin
      collision <= is_mii_on(enabled, mode) && col_lvl;
    end
  end

  // ==========================================================================
  // SMII capture: four independent serial lines, one bit each per edge
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      serial_bit <= 4'h0;
      serial_bit_valid <= 1'b0;
    end else begin
      serial_bit_valid <= 1'b0;
      if (enabled && bit_edge) begin
        serial_bit <= nib_lvl;
        serial_bit_valid <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // Receive segment start: srcsync follows the PHY pulse, plain SMII its own sync
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      serial_seg_start <= 1'b0;
    end else begin
      serial_seg_start <= 1'b0;
      if (enabled && bit_edge) begin
        if (mode == MODE_SRCSYNC) begin
          serial_seg_start <= dv_lvl;
        end else begin
          serial_seg_start <= (tx_seg_cnt == SEG_RESET);
        end
      end
    end
  end

  // ==========================================================================
  // Sync output generator: one pulse every ten clocks of the chosen clock
  // Plain mode counts reference clock rises, srcsync transmit clock rises
  assign sync_edge = (mode == MODE_SMII) ? refc_rise :
                     (mode == MODE_SRCSYNC) ? txc_rise : 1'b0;

  // Next segment count: wraps after the last bit of a segment
  always_comb begin
    next_tx_seg_cnt = tx_seg_cnt;
    if (sync_edge) begin
      next_tx_seg_cnt = (tx_seg_cnt == SEG_LAST) ? SEG_RESET : tx_seg_cnt + 4'h1;
    end
  end

  // Pulse stands from the edge that starts a segment to the next edge
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      tx_seg_cnt <= SEG_RESET;
      sense_sync_out <= 1'b0;
    end else if (!is_serial_on(enabled, mode)) begin
      tx_seg_cnt <= SEG_RESET; // Restart framing on every enable
      sense_sync_out <= 1'b0;
    end else begin
      tx_seg_cnt <= next_tx_seg_cnt;
      if (sync_edge) begin
        sense_sync_out <= (tx_seg_cnt == SEG_RESET);
      end
    end
  end

  // ==========================================================================
  // Pin direction: undriven in reset and MII, driven in every other enabled mode code
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      sense_sync_oe <= 1'b0;
    end else begin
      sense_sync_oe <= enabled && mode != MODE_MII;
    end
  end
endmodule // rx_front

// >>> verif/rx_front_monitor.sv
/* Checker on the rx_front ports.
   Assumes it is bound into rx_front and link periods of 4 clk_sys or more. */
`timescale 1ns/1ns
module rx_front_monitor
  import rx_front_pkg::*;
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic port_enable,
  input wire logic [1:0] port_mode,
  input wire logic sense_sync_oe,
  input wire logic sense_sync_out,
  input wire logic [NIBBLE_W-1:0] mii_nibble,
  input wire logic mii_nibble_valid,
  input wire logic carrier_sense,
  input wire logic collision,
  input wire logic serial_bit_valid,
  input wire logic serial_seg_start
);
  logic [3:0] nbits;
  logic seen;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  // ==========================================================================
  // Bits counted since the last segment start
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      nbits <= 4'h0;
      seen <= 1'b0;
    end else if (serial_bit_valid) begin
      nbits <= serial_seg_start ? 4'h0 : nbits + 4'h1;
      seen <= seen | serial_seg_start;
    end
  end
  AST_OE_OFF: assert property ((!port_enable || port_mode == MODE_MII) [*2] |-> !sense_sync_oe)
    else $error("pin driven");
  AST_OE_ON: assert property ((port_enable && port_mode == MODE_SMII) [*3] |-> sense_sync_oe)
    else $error("pin not driven");
  AST_COL_OFF: assert property ((port_mode != MODE_MII) [*2] |-> !collision && !carrier_sense)
    else $error("collision used");
  AST_QUIET: assert property ((!port_enable) [*6] |-> !mii_nibble_valid && !serial_bit_valid)
    else $error("disabled port active");
  AST_NIB_PULSE: assert property (mii_nibble_valid |=> !mii_nibble_valid)
    else $error("nibble pulse long");
  AST_NIB_HOLD: assert property (!mii_nibble_valid |-> $stable(mii_nibble))
    else $error("nibble moved");
  AST_SER_MODE: assert property (serial_bit_valid |-> port_enable && port_mode != MODE_MII)
    else $error("serial bit in MII");
  AST_SEG: assert property (serial_seg_start |-> serial_bit_valid && (!seen || nbits == SEG_LAST))
    else $error("segment length");
  AST_SYNC_SEG: assert property ($rose(sense_sync_out) && port_mode == MODE_SMII |-> serial_seg_start)
    else $error("sync pulse off segment start");
  AST_PIN_IDLE: assert property (!sense_sync_oe |-> !sense_sync_out)
    else $error("sync pulse on undriven pin");
  COV_NIB: cover property (mii_nibble_valid);
  COV_SEG: cover property (serial_seg_start);
  COV_SYNC: cover property ($rose(sense_sync_out));
endmodule // rx_front_monitor

bind rx_front rx_front_monitor i_mon (.clk_sys(clk_sys), .srst(srst), .port_enable(port_enable),
  .port_mode(port_mode), .sense_sync_oe(sense_sync_oe), .sense_sync_out(sense_sync_out),
  .mii_nibble(mii_nibble), .mii_nibble_valid(mii_nibble_valid), .carrier_sense(carrier_sense),
  .collision(collision), .serial_bit_valid(serial_bit_valid), .serial_seg_start(serial_seg_start));

// >>> verif/phy_model.sv
/* PHY partner: link clock, receive lines, valid or sync pulse, collision.
   Assumes the bench reads its outputs at the rising link edge. */
`timescale 1ns/1ns
module phy_model
  import rx_front_pkg::*;
(
  input wire logic [1:0] mode,
  output logic lk,
  output logic [3:0] nib,
  output logic dv,
  output logic col
);
  logic [3:0] n;
  // ==========================================================================
  // Link clock of 160 ns, twenty clk_sys periods, edges fixed 3 ns after a clk_sys edge
  initial begin
    {lk, nib, dv, col, n} = 11'h000;
    #3;
    forever #80 lk = ~lk; // Scaled-down receive clock; only slow sampled edges matter
  end
  // Lines change on the falling edge so they are steady at the rising edge
  always @(negedge lk) begin
    n = (n == 4'h9) ? 4'h0 : n + 4'h1;
    nib = 4'($urandom);
    dv = (mode == MODE_SRCSYNC) ? (n == 4'h0) : 1'($urandom);
    col = 1'($urandom);
  end
endmodule // phy_model

// >>> verif/rx_front_tb.sv
/* Bench for rx_front with a PHY partner and a queue of expected captures.
   Assumes the package, design, checker and phy_model compile first. */
`timescale 1ns/1ns
module rx_front_tb;
  import rx_front_pkg::*;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic port_enable = 1'b0;
  logic crs = 1'b0;
  logic [1:0] port_mode = MODE_MII;
  logic lk, dv, col, oe, so, mv, cs, sv, ss, co;
  logic [3:0] nib, mn, sb;
  logic [5:0] e;
  logic [5:0] q[$];
  int n_errors = 0;
  int n_compared = 0;
  int cyc = 0;
  int gap = 0;
  // ==========================================================================
  // Clock, partner and design
  always #4 clk_sys = ~clk_sys;
  phy_model i_phy (.mode(port_mode), .lk(lk), .nib(nib), .dv(dv), .col(col));
  rx_front i_dut (.clk_sys(clk_sys), .srst(srst), .port_enable(port_enable), .port_mode(port_mode),
    .port_rx_clock(lk), .shared_serial_ref_clock(lk), .srcsync_tx_clock(lk), .port_rx_nibble(nib),
    .port_rx_valid(dv), .port_collision(col), .sense_sync_in(oe ? so : crs), .sense_sync_out(so),
    .sense_sync_oe(oe), .mii_nibble(mn), .mii_nibble_valid(mv), .carrier_sense(cs), .collision(co),
    .serial_bit(sb), .serial_bit_valid(sv), .serial_seg_start(ss));
  task chk(input string nm, input logic [3:0] seen, input logic [3:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task give_verdict;
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Note each capture the design owes at a rising link edge; check the slow levels there too
  always @(posedge lk) begin
    if (port_enable && (port_mode == MODE_MII ? dv : port_mode != 2'b10))
      q.push_back({port_mode == MODE_SRCSYNC, dv, nib});
    chk("col", 4'(co), 4'(port_enable && port_mode == MODE_MII && col));
    if (!port_enable || port_mode == MODE_MII) begin
      gap = 0;
    end else if (so) begin
      if (gap > 0) chk("sync", 4'(gap), 4'(SEG_BITS));
      gap = 1;
    end else if (gap > 0 && gap < 15) begin
      gap++;
    end
  end
  // Compare each capture with the oldest note; cut a hang short
  always @(posedge clk_sys) begin
    #1;
    if (mv || sv) begin
      chk("note", 4'(q.size() > 0), 4'h1);
      e = q.size() > 0 ? q.pop_front() : 6'h00;
      chk("data", mv ? mn : sb, e[3:0]);
      if (e[5]) chk("seg", 4'(ss), 4'(e[4]));
    end
    cyc++;
    if (cyc == 12000) begin
      n_errors++;
      give_verdict();
    end
  end
  // Reset, then run one mode for 40 link periods
  task run(input logic [1:0] m, input logic en);
    srst = 1'b1;
    repeat (5) @(posedge clk_sys);
    #1 srst = 1'b0;
    port_mode = m;
    @(negedge lk);
    @(posedge clk_sys);
    #1 port_enable = en;
    repeat (40) @(posedge lk);
    @(posedge clk_sys);
    #1 chk("oe", 4'(oe), 4'(en && m != MODE_MII));
    if (m == MODE_SMII || m == MODE_SRCSYNC) chk("synced", 4'(gap > 0), 4'(en));
    @(negedge lk);
    @(posedge clk_sys);
    #1 port_enable = 1'b0;
    repeat (8) @(posedge clk_sys);
    #1 chk("left", 4'(q.size()), 4'h0);
    $display("test mode %0d enable %0d done", m, en);
  endtask
  // Main sequence
  initial begin
    void'($urandom(34840));
    run(MODE_MII, 1'b1);
    run(MODE_SMII, 1'b1);
    run(MODE_SRCSYNC, 1'b1);
    run(2'b10, 1'b1);
    run(MODE_MII, 1'b0);
    @(negedge lk);
    @(posedge clk_sys);
    #1 port_enable = 1'b1;
    crs = 1'b1; // Medium active, held through any collision
    repeat (6) @(posedge clk_sys);
    #1 chk("crs", 4'(cs), 4'h1);
    crs = 1'b0; // Medium idle; collision still random from the PHY
    repeat (6) @(posedge clk_sys);
    #1 chk("crs", 4'(cs), 4'h0);
    $display("test carrier done");
    give_verdict();
  end
endmodule // rx_front_tb
